// ===== design/tef_pkg.sv
package tef_pkg;

  // Register data width and bus address width
  localparam int DATA_W = 16;
  localparam int ADR_W  = 8;

  // Byte offsets of the registers
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_IEN      = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_EVGEN    = 8'h14;
  localparam logic [7:0] ADDR_MODE1    = 8'h18;
  localparam logic [7:0] ADDR_COUNT    = 8'h24;
  localparam logic [7:0] ADDR_PSC      = 8'h28;
  localparam logic [7:0] ADDR_RELOAD   = 8'h2C;
  localparam logic [7:0] ADDR_CH1      = 8'h34;
  localparam logic [7:0] ADDR_CH2      = 8'h38;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h40;

  // Bit positions in status, event generation and enables; BIT_RC1 is a status bit only, BIT_DMA1 an enable bit only
  localparam int BIT_UPD = 0;
  localparam int BIT_CH1 = 1;
  localparam int BIT_COM = 5;
  localparam int BIT_TRG = 6;
  localparam int BIT_BRK = 7;
  localparam int BIT_RC1 = 9;
  localparam int BIT_DMA1 = 9;

  // Control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_DOWN = 4;
  localparam int CTRL_CMS  = 5;

  // Channel mode byte fields, one byte per channel
  localparam int MODE_STRIDE  = 8;
  localparam int MODE_SEL     = 0;
  localparam int MODE_PRELOAD = 3;

  // Writable bits of control and enables, and the bits that may raise the interrupt
  localparam logic [15:0] CTRL_MASK   = 16'h0071;
  localparam logic [15:0] IEN_MASK    = 16'h06E7;
  localparam logic [15:0] IRQ_SRC     = 16'h00E7;

  // Values after reset
  localparam logic [15:0] RST_ZERO    = 16'h0000;
  localparam logic [15:0] RST_RELOAD  = 16'hFFFF;

endpackage

// ===== design/tef_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pins from outside the clock domain
module tef_sync
  import tef_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// ===== design/tef_prescaler.sv
`timescale 1ns/1ps
// Prescaler: divides the clock by factor_i + 1 into a tick enable
module tef_prescaler
  import tef_pkg::*;
#(
  parameter int W = DATA_W
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         run_i,
  input  wire logic         clear_i,
  input  wire logic [W-1:0] factor_i,
  output logic              tick_o
);

  logic [W-1:0] div_cnt;

  // Tick when the divider reaches the factor; a clear suppresses it
  assign tick_o = run_i & ~clear_i & (div_cnt == factor_i);

  // Clear resets only the divider, never the programmed factor
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_cnt <= '0;
    else if (clear_i)
      div_cnt <= '0;
    else if (run_i)
    begin
      if (div_cnt >= factor_i)
        div_cnt <= '0;
      else
        div_cnt <= div_cnt + W'(1);
    end
  end

endmodule

// ===== design/tef_top.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module tef_top
  import tef_pkg::*;
#(
  parameter int NCH = 2
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              break_i,
  input  wire logic [NCH-1:0]    cap_i,
  output logic                   irq_o,
  output logic      [NCH-1:0]    dma_req_o,
  output logic                   update_evt_o,
  output logic                   com_evt_o,
  output logic                   trigger_evt_o,
  output logic                   break_evt_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word address match, low address bits ignored
  function automatic logic hit(input logic [ADR_W-1:0] a, input logic [7:0] off);
    return a[ADR_W-1:2] == off[ADR_W-1:2];
  endfunction

  // Any non-zero direction code makes the channel a capture input
  function automatic logic is_input(input logic [1:0] sel);
    return sel != 2'b00;
  endfunction

  // Byte-lane merge of a write into a register
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [DATA_W-1:0] m);
    return (old_v & ~m) | (new_v & m);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic              bus_req;
  logic              bus_wr;
  logic              bus_rd;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wdat;
  logic [DATA_W-1:0] ctrl;
  logic [DATA_W-1:0] ien;
  logic [DATA_W-1:0] mode1;
  logic [DATA_W-1:0] count;
  logic [DATA_W-1:0] psc_factor;
  logic [DATA_W-1:0] reload;
  logic [DATA_W-1:0] irq_stat;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] status_clr;
  logic [DATA_W-1:0] event_set;
  logic [DATA_W-1:0] evgen_wr;
  logic              upd_flag;
  logic              com_flag;
  logic              trg_flag;
  logic              brk_flag;
  logic              brk_sync;
  logic [NCH-1:0]    cap_sync;
  logic [NCH-1:0]    cap_prev;
  logic              tick;
  logic              count_down;
  logic              force_upd;
  logic              hw_wrap;
  logic              update_evt;
  logic              brk_evt;
  logic [NCH-1:0]    ch_set;
  logic [NCH-1:0]    ch_flag;
  logic [NCH-1:0]    rep_flag;
  logic [DATA_W-1:0] ccr     [NCH];

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one access per request, answered on the next edge

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;
  assign bus_rd  = bus_req & ~wb_we_i;
  assign wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat    = wb_dat_i[DATA_W-1:0];

  // Ack drops the cycle after it was given, so no access is taken twice
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  // Event generation bits exist only in the cycle of the write
  assign evgen_wr = (bus_wr && hit(wb_adr_i, ADDR_EVGEN)) ? (wdat & wmask) : RST_ZERO;

  // Status bits written as zero are cleared; ones leave them alone
  assign status_clr = (bus_wr && hit(wb_adr_i, ADDR_STATUS)) ? (~wdat & wmask) : RST_ZERO;

  //////////////////////////////////////////////////////////////////////////////
  // Plain configuration registers

  // Control, enables and reload
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl       <= RST_ZERO;
      ien        <= RST_ZERO;
      psc_factor <= RST_ZERO;
      reload     <= RST_RELOAD;
    end
    else if (bus_wr)
    begin
      if (hit(wb_adr_i, ADDR_CTRL))
        ctrl <= merge(ctrl, wdat, wmask) & CTRL_MASK;
      if (hit(wb_adr_i, ADDR_IEN))
        ien <= merge(ien, wdat, wmask) & IEN_MASK;
      if (hit(wb_adr_i, ADDR_PSC))
        psc_factor <= merge(psc_factor, wdat, wmask);
      if (hit(wb_adr_i, ADDR_RELOAD))
        reload <= merge(reload, wdat, wmask);
    end
  end

  // Mode register: one byte per channel, decoded per direction below
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode1 <= RST_ZERO;
    else if (bus_wr && hit(wb_adr_i, ADDR_MODE1))
      mode1 <= merge(mode1, wdat, wmask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and prescaler

  tef_sync #(.W(NCH + 1)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({cap_i, break_i}),
    .q_o   ({cap_sync, brk_sync})
  );

  tef_prescaler #(.W(DATA_W)) u_psc (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .run_i    (ctrl[CTRL_EN]),
    .clear_i  (update_evt),
    .factor_i (psc_factor),
    .tick_o   (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Counter and update event

  // Centre-aligned modes count up here; only edge modes may count down
  assign count_down = ctrl[CTRL_DOWN] & (ctrl[CTRL_CMS +: 2] == 2'b00);
  assign force_upd  = evgen_wr[BIT_UPD];
  assign hw_wrap    = tick & (count_down ? (count == RST_ZERO) : (count == reload));
  assign update_evt = force_upd | hw_wrap;

  // A forced update wins over counting and over a software write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= RST_ZERO;
    else if (force_upd)
      count <= count_down ? reload : RST_ZERO;
    else if (bus_wr && hit(wb_adr_i, ADDR_COUNT))
      count <= merge(count, wdat, wmask);
    else if (hw_wrap)
      count <= count_down ? reload : RST_ZERO;
    else if (tick)
      count <= count_down ? count - DATA_W'(1) : count + DATA_W'(1);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capture/compare channels

  // Previous synchronised capture level for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cap_prev <= '0;
    else
      cap_prev <= cap_sync;
  end

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
      logic [7:0]        mode_byte;
      logic              in_mode;
      logic              force_ev;
      logic              capture;
      logic              match;
      logic              reg_wr;
      logic              reg_rd;
      logic [DATA_W-1:0] shadow;
      logic [7:0]        reg_off;

      assign reg_off   = (g == 0) ? ADDR_CH1 : ADDR_CH2;
      assign mode_byte = mode1[g*MODE_STRIDE +: MODE_STRIDE];
      assign in_mode   = is_input(mode_byte[MODE_SEL +: 2]);
      assign force_ev  = evgen_wr[BIT_CH1 + g];
      assign capture   = in_mode & (force_ev | (cap_sync[g] & ~cap_prev[g]));
      assign match     = ~in_mode & tick & (count == ccr[g]);
      assign ch_set[g] = capture | match | (~in_mode & force_ev);
      assign reg_wr    = bus_wr & hit(wb_adr_i, reg_off);
      assign reg_rd    = bus_rd & hit(wb_adr_i, reg_off);

      // Preload only means something in output mode; input mode is read-only
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          ccr[g] <= RST_ZERO;
          shadow <= RST_ZERO;
        end
        else if (capture)
          ccr[g] <= count;
        else if (!in_mode)
        begin
          if (reg_wr)
            shadow <= merge(shadow, wdat, wmask);
          if (reg_wr && !mode_byte[MODE_PRELOAD])
            ccr[g] <= merge(ccr[g], wdat, wmask);
          else if (update_evt && mode_byte[MODE_PRELOAD])
            ccr[g] <= shadow;
        end
      end

      // Event flag: set wins over a write of zero or a register read
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          ch_flag[g] <= 1'b0;
        else if (ch_set[g])
          ch_flag[g] <= 1'b1;
        else if (status_clr[BIT_CH1 + g] || reg_rd)
          ch_flag[g] <= 1'b0;
      end

      // Repeat flag: capture while the event flag is still pending
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          rep_flag[g] <= 1'b0;
        else if (capture && ch_flag[g])
          rep_flag[g] <= 1'b1;
        else if (status_clr[BIT_RC1 + g])
          rep_flag[g] <= 1'b0;
      end

      // DMA request pulse when the flag is set and DMA is enabled
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          dma_req_o[g] <= 1'b0;
        else
          dma_req_o[g] <= ch_set[g] & ien[BIT_DMA1 + g];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Timer-wide flags

  assign brk_evt = brk_sync | evgen_wr[BIT_BRK];

  // Update, control-update and trigger flags; set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      upd_flag <= 1'b0;
      com_flag <= 1'b0;
      trg_flag <= 1'b0;
    end
    else
    begin
      upd_flag <= update_evt | (upd_flag & ~status_clr[BIT_UPD]);
      com_flag <= evgen_wr[BIT_COM] | (com_flag & ~status_clr[BIT_COM]);
      trg_flag <= evgen_wr[BIT_TRG] | (trg_flag & ~status_clr[BIT_TRG]);
    end
  end

  // Break flag cannot be cleared while the break input is still active
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      brk_flag <= 1'b0;
    else if (brk_evt)
      brk_flag <= 1'b1;
    else if (status_clr[BIT_BRK] && !brk_sync)
      brk_flag <= 1'b0;
  end

  // Event pulses toward the counter core, channels and break logic
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      update_evt_o  <= 1'b0;
      com_evt_o     <= 1'b0;
      trigger_evt_o <= 1'b0;
      break_evt_o   <= 1'b0;
    end
    else
    begin
      update_evt_o  <= update_evt;
      com_evt_o     <= evgen_wr[BIT_COM];
      trigger_evt_o <= evgen_wr[BIT_TRG];
      break_evt_o   <= evgen_wr[BIT_BRK];
    end
  end

  // Reserved bits of the status word stay zero
  assign status = {5'b0_0000, rep_flag[1], rep_flag[0], 1'b0, brk_flag, trg_flag, com_flag,
                   2'b00, ch_flag[1], ch_flag[0], upd_flag};

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt: sticky events, cleared by reading them, gated by enables

  assign event_set = {8'h00, brk_evt, evgen_wr[BIT_TRG], evgen_wr[BIT_COM], 2'b00, ch_set, update_evt};

  // A new event in the reading cycle survives the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat <= RST_ZERO;
    else if (bus_rd && hit(wb_adr_i, ADDR_IRQ_STAT))
      irq_stat <= event_set;
    else
      irq_stat <= irq_stat | event_set;
  end

  assign irq_o = |(irq_stat & ien & IRQ_SRC);

  //////////////////////////////////////////////////////////////////////////////
  // Read data, registered with the ack; unmapped words read zero

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_rd)
    begin
      wb_dat_o <= 32'h0000_0000;
      if (hit(wb_adr_i, ADDR_CTRL))
        wb_dat_o[DATA_W-1:0] <= ctrl;
      if (hit(wb_adr_i, ADDR_IEN))
        wb_dat_o[DATA_W-1:0] <= ien;
      if (hit(wb_adr_i, ADDR_STATUS))
        wb_dat_o[DATA_W-1:0] <= status;
      if (hit(wb_adr_i, ADDR_MODE1))
        wb_dat_o[DATA_W-1:0] <= mode1;
      if (hit(wb_adr_i, ADDR_COUNT))
        wb_dat_o[DATA_W-1:0] <= count;
      if (hit(wb_adr_i, ADDR_PSC))
        wb_dat_o[DATA_W-1:0] <= psc_factor;
      if (hit(wb_adr_i, ADDR_RELOAD))
        wb_dat_o[DATA_W-1:0] <= reload;
      if (hit(wb_adr_i, ADDR_CH1))
        wb_dat_o[DATA_W-1:0] <= ccr[0];
      if (hit(wb_adr_i, ADDR_CH2))
        wb_dat_o[DATA_W-1:0] <= ccr[1];
      if (hit(wb_adr_i, ADDR_IRQ_STAT))
        wb_dat_o[DATA_W-1:0] <= irq_stat;
    end
  end

endmodule

// ===== verif/tef_top_props.sv
`timescale 1ns/1ps
module tef_top_props
  import tef_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        update_evt_o,
  input  wire logic        com_evt_o,
  input  wire logic        trigger_evt_o,
  input  wire logic        break_evt_o
);
  ////////////////////////////////////////////////////////////
  // Taken requests; ack low keeps the answer cycle from counting twice
  wire tk  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire hit = wb_adr_i[7:2] == ADDR_EVGEN[7:2];
  wire evw = tk & wb_we_i & wb_sel_i[0] & hit;
  wire evr = tk & ~wb_we_i & hit;
  wire e_u = evw & wb_dat_i[BIT_UPD];
  wire e_c = evw & wb_dat_i[BIT_COM];
  wire e_t = evw & wb_dat_i[BIT_TRG];
  wire e_b = evw & wb_dat_i[BIT_BRK];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////
  property p_ack_next; tk |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_upd_force; e_u |-> ##[1:2] update_evt_o; endproperty
  a_upd_force: assert property (p_upd_force) else $error("no update");
  property p_com_force; e_c |-> ##[1:2] com_evt_o; endproperty
  a_com_force: assert property (p_com_force) else $error("no ctrl upd");
  property p_trg_force; e_t |-> ##[1:2] trigger_evt_o; endproperty
  a_trg_force: assert property (p_trg_force) else $error("no trigger");
  property p_brk_force; e_b |-> ##[1:2] break_evt_o; endproperty
  a_brk_force: assert property (p_brk_force) else $error("no break");
  property p_com_cause; com_evt_o |-> $past(e_c) || $past(e_c, 2); endproperty
  a_com_cause: assert property (p_com_cause) else $error("stray ctrl upd");
  property p_trg_cause; trigger_evt_o |-> $past(e_t) || $past(e_t, 2); endproperty
  a_trg_cause: assert property (p_trg_cause) else $error("stray trigger");
  property p_brk_cause; break_evt_o |-> $past(e_b) || $past(e_b, 2); endproperty
  a_brk_cause: assert property (p_brk_cause) else $error("stray break");
  property p_evgen_rd0; evr |=> wb_dat_o == 32'h0000_0000; endproperty
  a_evgen_rd0: assert property (p_evgen_rd0) else $error("evgen reads");
  property p_hi_zero; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits");
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb
  import tef_pkg::*;
;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        break_i, irq_o, update_evt_o, com_evt_o, trigger_evt_o, break_evt_o;
  logic [1:0]  cap_i, dma_req_o;
  int          fails, compares, cycles, n_upd, n_com, n_trg, n_brk, n_dma;

  tef_top #(.NCH(2)) tef_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .break_i(break_i),
    .cap_i(cap_i), .irq_o(irq_o), .dma_req_o(dma_req_o), .update_evt_o(update_evt_o),
    .com_evt_o(com_evt_o), .trigger_evt_o(trigger_evt_o), .break_evt_o(break_evt_o));

  ////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Count event pulses; a pulse stuck high shows as an excess count
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (update_evt_o === 1'b1) n_upd <= n_upd + 1;
    if (com_evt_o === 1'b1) n_com <= n_com + 1;
    if (trigger_evt_o === 1'b1) n_trg <= n_trg + 1;
    if (break_evt_o === 1'b1) n_brk <= n_brk + 1;
    if (dma_req_o !== 2'b00) n_dma <= n_dma + 1;
    if (cycles == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] dat, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, dat};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
    logic [31:0] q;
    bus(1'b1, adr, dat, q);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, adr, 16'h0000, q);
    check(q, exp, what);
  endtask

  // Hold a pin for a few cycles so it clears the two-flop synchroniser
  task automatic pin_wait();
    repeat (5) @(posedge clk_i);
  endtask

  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0000_0000;
    break_i = 1'b0;
    cap_i = 2'b00;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(ADDR_EVGEN, 32'h0000_0000, "evgen rst");
    rdc(ADDR_MODE1, 32'h0000_0000, "mode rst");
    rdc(ADDR_STATUS, 32'h0000_0000, "status rst");
    rdc(8'hF0, 32'h0000_0000, "unmapped");
    $display("test reset done");
    wr(ADDR_RELOAD, 16'h0040);
    wr(ADDR_PSC, 16'h0003);
    wr(ADDR_COUNT, 16'h0010);
    wr(ADDR_EVGEN, 16'h0001);
    rdc(ADDR_COUNT, 32'h0000_0000, "count up");
    rdc(ADDR_STATUS, 32'h0000_0001, "update flag");
    rdc(ADDR_EVGEN, 32'h0000_0000, "evgen clr");
    wr(ADDR_STATUS, 16'h0000);
    rdc(ADDR_STATUS, 32'h0000_0000, "update clr");
    wr(ADDR_CTRL, 16'h0010);
    wr(ADDR_EVGEN, 16'h0001);
    rdc(ADDR_COUNT, 32'h0000_0040, "count down");
    wr(ADDR_CTRL, 16'h0030);
    wr(ADDR_EVGEN, 16'h0001);
    rdc(ADDR_COUNT, 32'h0000_0000, "count centre");
    rdc(ADDR_PSC, 32'h0000_0003, "psc kept");
    check(n_upd, 3, "update pulses");
    wr(ADDR_STATUS, 16'h0000);
    $display("test update done");
    wr(ADDR_IEN, 16'h0202);
    wr(ADDR_EVGEN, 16'h0002);
    rdc(ADDR_STATUS, 32'h0000_0002, "ch1 out flag");
    check(irq_o, 1'b1, "irq on");
    check(n_dma, 1, "dma pulse");
    rdc(ADDR_CH1, 32'h0000_0000, "no capture");
    rdc(ADDR_STATUS, 32'h0000_0000, "read clears");
    // Update bit is still sticky from the forced updates above
    rdc(ADDR_IRQ_STAT, 32'h0000_0003, "irq sticky");
    check(irq_o, 1'b0, "irq off");
    wr(ADDR_IEN, 16'h0000);
    wr(ADDR_EVGEN, 16'h0004);
    check(irq_o, 1'b0, "irq masked");
    rdc(ADDR_IRQ_STAT, 32'h0000_0004, "irq masked stat");
    wr(ADDR_STATUS, 16'h0000);
    $display("test output done");
    wr(ADDR_MODE1, 16'h0101);
    wr(ADDR_COUNT, 16'h0025);
    repeat (2) wr(ADDR_EVGEN, 16'h0002);
    repeat (2) wr(ADDR_EVGEN, 16'h0004);
    rdc(ADDR_STATUS, 32'h0000_0606, "repeat flags");
    rdc(ADDR_CH1, 32'h0000_0025, "ch1 capture");
    rdc(ADDR_CH2, 32'h0000_0025, "ch2 capture");
    rdc(ADDR_STATUS, 32'h0000_0600, "flags read");
    wr(ADDR_STATUS, 16'h0000);
    rdc(ADDR_STATUS, 32'h0000_0000, "repeat clr");
    wr(ADDR_CH1, 16'h1111);
    rdc(ADDR_CH1, 32'h0000_0025, "ch1 no write");
    wr(ADDR_COUNT, 16'h0033);
    cap_i <= 2'b01;
    pin_wait();
    cap_i <= 2'b00;
    rdc(ADDR_CH1, 32'h0000_0033, "pin capture");
    wr(ADDR_STATUS, 16'h0000);
    wr(ADDR_MODE1, 16'h0000);
    $display("test input done");
    wr(ADDR_IEN, 16'h00E0);
    wr(ADDR_EVGEN, 16'h00E0);
    rdc(ADDR_STATUS, 32'h0000_00E0, "evt flags");
    check(irq_o, 1'b1, "evt irq");
    // Channel bits stay sticky from the captures of the input test
    rdc(ADDR_IRQ_STAT, 32'h0000_00E6, "evt irq stat");
    wr(ADDR_STATUS, 16'h0000);
    wr(ADDR_EVGEN, 16'hFF18);
    wr(ADDR_STATUS, 16'hFFFF);
    rdc(ADDR_STATUS, 32'h0000_0000, "reserved");
    check({n_com[7:0], n_trg[7:0], n_brk[7:0]}, 24'h01_0101, "evt pulses");
    break_i <= 1'b1;
    pin_wait();
    wr(ADDR_STATUS, 16'h0000);
    rdc(ADDR_STATUS, 32'h0000_0080, "break held");
    break_i <= 1'b0;
    pin_wait();
    wr(ADDR_STATUS, 16'h0000);
    rdc(ADDR_STATUS, 32'h0000_0000, "break clr");
    check(n_brk, 1, "pin no evt");
    check(n_dma, 1, "dma masked");
    $display("test events done");
    report_and_stop();
  end
endmodule

bind tef_top tef_top_props tef_top_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .update_evt_o(update_evt_o),
  .com_evt_o(com_evt_o), .trigger_evt_o(trigger_evt_o), .break_evt_o(break_evt_o));
